// *** dmas_pkg.sv ***
package dmas_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] OFS_MODE  = 8'h00;
	localparam logic [7:0] OFS_SRC   = 8'h04;
	localparam logic [7:0] OFS_DST   = 8'h08;
	localparam logic [7:0] OFS_TCNT  = 8'h0c;
	localparam logic [7:0] OFS_BSIZE = 8'h10;
	localparam logic [7:0] OFS_AREA  = 8'h14;
	localparam logic [7:0] OFS_MRSS  = 8'h18;
	localparam logic [7:0] OFS_STAT  = 8'h1c;
	localparam logic [7:0] OFS_MASK  = 8'h20;

	// channel_mode_control fields
	localparam int MD_EN    = 0;
	localparam int MD_SGL   = 1;
	localparam int MD_XM    = 2;
	localparam int MD_ACT   = 4;
	localparam int MD_BURST = 6;
	localparam int MD_DIR   = 7;
	localparam int MD_SIZE  = 8;
	localparam int MD_SMOD  = 10;
	localparam int MD_DMOD  = 12;
	localparam int MD_RPT   = 14;

	// wrap area register fields
	localparam int AR_DSEL = 0;
	localparam int AR_DIE  = 7;
	localparam int AR_SSEL = 8;
	localparam int AR_SIE  = 15;
	localparam logic [15:0] AREA_WMASK = 16'h9f9f;

	// status and mask bits
	localparam int ST_ESF  = 0;
	localparam int ST_END  = 1;
	localparam int ST_BADA = 2;
	localparam int STAT_W  = 3;

	// reset values and special codes
	localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
	localparam logic [4:0]  AREA_OFF     = 5'h00;
	localparam logic [2:0]  AREA_BAD_TOP = 3'h7;
	localparam logic [7:0]  MRSS_NONE    = 8'h00;
	localparam logic [16:0] BSIZE_MAX    = 17'h1_0000;
	localparam logic [15:0] BSIZE_ZERO   = 16'h0000;
	localparam logic [2:0]  STEP_ONE     = 3'h1;
	localparam logic [2:0]  STEP_NONE    = 3'h0;
	localparam logic [1:0]  RESP_OK      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		XM_NORMAL = 2'h0,
		XM_REPEAT = 2'h1,
		XM_BLOCK  = 2'h2
	} dmas_xmode_e;

	typedef enum logic [1:0] {
		ACT_AUTO   = 2'h0,
		ACT_MODULE = 2'h1,
		ACT_EXT    = 2'h2
	} dmas_act_e;

	typedef enum logic [1:0] {
		AM_FIX = 2'h0,
		AM_INC = 2'h1,
		AM_DEC = 2'h2
	} dmas_amode_e;

	typedef enum logic [1:0] {
		RS_NONE = 2'h0,
		RS_SRC  = 2'h1,
		RS_DST  = 2'h2
	} dmas_rside_e;

	typedef enum logic [4:0] {
		SM_IDLE = 5'b00001,
		SM_RD   = 5'b00010,
		SM_WR   = 5'b00100,
		SM_SGL  = 5'b01000,
		SM_GAP  = 5'b10000
	} dmas_state_e;

endpackage

// *** dmas_wrap_if.sv ***
`timescale 1ns/1ns
interface dmas_wrap_if;
	logic [31:0] addr;      // current address
	logic [2:0]  step;      // bytes per unit, zero when fixed
	logic        dec;       // decrement instead of increment
	logic [4:0]  area_sel;  // wrap window code
	logic [31:0] nxt_addr;  // address after the update
	logic        overflow;  // update left the window

	modport user (
		output addr,
		output step,
		output dec,
		output area_sel,
		input  nxt_addr,
		input  overflow
	);

	modport unit (
		input  addr,
		input  step,
		input  dec,
		input  area_sel,
		output nxt_addr,
		output overflow
	);
endinterface

// *** dmas_wrap_unit.sv ***
`timescale 1ns/1ns
module dmas_wrap_unit (
	// address update port
	dmas_wrap_if.unit w
);

	////////////////////////////////////////////////////////////////////////
	// window decode: 111xx codes are treated as no window
	wire        win_on = (w.area_sel != dmas_pkg::AREA_OFF) &&
	                     (w.area_sel[4:2] != dmas_pkg::AREA_BAD_TOP);
	wire [31:0] one    = {29'h0, dmas_pkg::STEP_ONE};
	wire [31:0] mask   = win_on ? ((one << w.area_sel) - one) : ~32'h0000_0000;
	wire [31:0] step32 = {29'h0, w.step};
	wire [31:0] raw    = w.dec ? (w.addr - step32) : (w.addr + step32);

	// upper bits frozen; low bits roll to start or end of the window
	assign w.nxt_addr = (w.addr & ~mask) | (raw & mask);
	assign w.overflow = win_on && ((raw & ~mask) != (w.addr & ~mask));

endmodule

// *** dmas_channel.sv ***
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
module dmas_channel (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// system bus cycle port
	output logic             bus_req,
	output logic [31:0]      bus_addr,
	output logic             bus_wr,
	output logic [1:0]       bus_size,
	output logic [31:0]      bus_wdata,
	input  wire logic [31:0] bus_rdata,
	input  wire logic        bus_done,
	output logic             periph_ack_strobe_n,
	// activation sources
	input  wire logic [7:0]  mod_irq_vec,
	input  wire logic        mod_irq_valid,
	input  wire logic        ext_req_n,
	// interrupt
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	// state
	logic [15:0] mode_ff, area_ff, bsize_ff;
	logic [31:0] src_ff, dst_ff, src0_ff, dst0_ff, tcnt_ff, data_ff;
	logic [7:0]  mrss_ff;
	logic [dmas_pkg::STAT_W-1:0] stat_ff, mask_ff;
	logic [16:0] ucnt_ff;
	logic        ovf_pend_ff, mod_pend_ff;
	logic        ext_s1_ff, ext_s2_ff, ext_s3_ff, ext_lvl_ff;
	logic [31:0] bus_addr_ff;
	logic        bus_wr_ff, ack_n_ff;
	dmas_pkg::dmas_state_e st_ff, nxt_st;
	// axi slave state
	logic [7:0]  wa_ff;
	logic [31:0] wd_ff;
	logic [3:0]  ws_ff;
	logic        aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// mode field views, all per channel
	wire        en    = mode_ff[dmas_pkg::MD_EN];
	wire        sgl   = mode_ff[dmas_pkg::MD_SGL];
	wire [1:0]  xm    = mode_ff[dmas_pkg::MD_XM+:2];
	wire [1:0]  act   = mode_ff[dmas_pkg::MD_ACT+:2];
	wire        burst = mode_ff[dmas_pkg::MD_BURST];
	wire        dir   = mode_ff[dmas_pkg::MD_DIR];
	wire [1:0]  size  = mode_ff[dmas_pkg::MD_SIZE+:2];
	wire [1:0]  smod  = mode_ff[dmas_pkg::MD_SMOD+:2];
	wire [1:0]  dmod  = mode_ff[dmas_pkg::MD_DMOD+:2];
	wire [1:0]  rside = mode_ff[dmas_pkg::MD_RPT+:2];
	wire [2:0]  step  = 3'(dmas_pkg::STEP_ONE << size);
	wire        is_auto = act == dmas_pkg::ACT_AUTO;

	////////////////////////////////////////////////////////////////////////
	// wrap units for both address sides
	dmas_wrap_if src_w ();
	dmas_wrap_if dst_w ();
	assign src_w.addr     = src_ff;
	assign src_w.step     = (smod == dmas_pkg::AM_FIX) ? dmas_pkg::STEP_NONE
	                                                   : step;
	assign src_w.dec      = smod == dmas_pkg::AM_DEC;
	assign src_w.area_sel = area_ff[dmas_pkg::AR_SSEL+:5];
	assign dst_w.addr     = dst_ff;
	assign dst_w.step     = (dmod == dmas_pkg::AM_FIX) ? dmas_pkg::STEP_NONE
	                                                   : step;
	assign dst_w.dec      = dmod == dmas_pkg::AM_DEC;
	assign dst_w.area_sel = area_ff[dmas_pkg::AR_DSEL+:5];
	dmas_wrap_unit u_src_wrap (.w(src_w));
	dmas_wrap_unit u_dst_wrap (.w(dst_w));

	////////////////////////////////////////////////////////////////////////
	// unit completion bookkeeping
	// single mode moves only the memory side; the peripheral has no address
	wire upd_src   = !sgl || !dir;
	wire upd_dst   = !sgl || dir;
	wire unit_done = bus_done && (st_ff == dmas_pkg::SM_WR ||
	                              st_ff == dmas_pkg::SM_SGL);
	wire [16:0] bsz_eff = (bsize_ff == dmas_pkg::BSIZE_ZERO) ?
	                      dmas_pkg::BSIZE_MAX : {1'b0, bsize_ff};
	wire [16:0] ucnt_inc = ucnt_ff + 17'h0_0001;
	wire rpt_hit  = (xm != dmas_pkg::XM_NORMAL) && ucnt_inc == bsz_eff;
	wire blk_more = (xm == dmas_pkg::XM_BLOCK) && !rpt_hit;
	wire free_run = tcnt_ff == dmas_pkg::RST_ZERO;
	wire tc_end   = !free_run && tcnt_ff <= {29'h0, step};
	wire ovf_hit  = (upd_src && src_w.overflow && area_ff[dmas_pkg::AR_SIE])
	             || (upd_dst && dst_w.overflow && area_ff[dmas_pkg::AR_DIE]);
	// block mode defers the overflow stop until the block is complete
	wire ovf_stop = (ovf_hit || ovf_pend_ff) && !blk_more;
	wire stop     = tc_end || ovf_stop;

	////////////////////////////////////////////////////////////////////////
	// activation sources
	wire mod_hit = mod_irq_valid && mod_irq_vec == mrss_ff &&
	               mrss_ff != dmas_pkg::MRSS_NONE;
	wire req = is_auto ||
	           (act == dmas_pkg::ACT_MODULE && mod_pend_ff) ||
	           (act == dmas_pkg::ACT_EXT && !ext_lvl_ff);
	wire start = st_ff == dmas_pkg::SM_IDLE && en && req;
	wire first_sgl = sgl;

	////////////////////////////////////////////////////////////////////////
	// transfer sequencer
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			dmas_pkg::SM_IDLE: begin
				if (start)
					nxt_st = first_sgl ? dmas_pkg::SM_SGL : dmas_pkg::SM_RD;
			end
			dmas_pkg::SM_RD: begin
				if (bus_done)
					nxt_st = dmas_pkg::SM_WR;
			end
			dmas_pkg::SM_WR, dmas_pkg::SM_SGL: begin
				if (!bus_done)
					nxt_st = st_ff;
				else if (stop)
					nxt_st = dmas_pkg::SM_IDLE;
				else if (blk_more || (is_auto && burst && en))
					nxt_st = first_sgl ? dmas_pkg::SM_SGL : dmas_pkg::SM_RD;
				else if (is_auto)
					nxt_st = dmas_pkg::SM_GAP;
				else
					nxt_st = dmas_pkg::SM_IDLE;
			end
			dmas_pkg::SM_GAP: nxt_st = dmas_pkg::SM_IDLE;
			default: nxt_st = dmas_pkg::SM_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// axi write decode
	wire        wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
	wire [31:0] wbm = {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}},
	                   {8{ws_ff[0]}}};
	wire ws_mode  = wr_fire && wa_ff == dmas_pkg::OFS_MODE;
	wire ws_src   = wr_fire && wa_ff == dmas_pkg::OFS_SRC;
	wire ws_dst   = wr_fire && wa_ff == dmas_pkg::OFS_DST;
	wire ws_tcnt  = wr_fire && wa_ff == dmas_pkg::OFS_TCNT;
	wire ws_bsize = wr_fire && wa_ff == dmas_pkg::OFS_BSIZE;
	wire ws_area  = wr_fire && wa_ff == dmas_pkg::OFS_AREA;
	wire ws_mrss  = wr_fire && wa_ff == dmas_pkg::OFS_MRSS;
	wire ws_stat  = wr_fire && wa_ff == dmas_pkg::OFS_STAT;
	wire ws_mask  = wr_fire && wa_ff == dmas_pkg::OFS_MASK;
	wire ws_hit   = ws_mode || ws_src || ws_dst || ws_tcnt || ws_bsize ||
	                ws_area || ws_mrss || ws_stat || ws_mask;

	function automatic logic [31:0] mrg(input logic [31:0] old);
		return (old & ~wbm) | (wd_ff & wbm);
	endfunction

	wire [31:0] m_mode = mrg({16'h0, mode_ff});
	wire [31:0] m_area = mrg({16'h0, area_ff}) & {16'h0, dmas_pkg::AREA_WMASK};
	wire [31:0] m_bsize = mrg({16'h0, bsize_ff});
	wire [31:0] m_mrss  = mrg({24'h0, mrss_ff});
	wire [31:0] m_mask  = mrg({29'h0, mask_ff});
	wire en_rise = ws_mode && m_mode[dmas_pkg::MD_EN] && !en;
	// prohibited wrap codes are flagged, then act as no window
	wire bad_area = ws_area &&
	    (m_area[dmas_pkg::AR_SSEL+2+:3] == dmas_pkg::AREA_BAD_TOP ||
	     m_area[dmas_pkg::AR_DSEL+2+:3] == dmas_pkg::AREA_BAD_TOP);

	////////////////////////////////////////////////////////////////////////
	// next register values
	logic [15:0] nxt_mode;
	logic [31:0] nxt_src, nxt_dst, nxt_tcnt, nxt_bus_addr;
	logic [dmas_pkg::STAT_W-1:0] st_set, st_clr;
	always_comb begin
		nxt_mode = ws_mode ? m_mode[15:0] : mode_ff;
		if (unit_done && stop)
			nxt_mode[dmas_pkg::MD_EN] = 1'b0;
		nxt_src = ws_src ? mrg(src_ff) : src_ff;
		if (unit_done && upd_src)
			nxt_src = (rpt_hit && rside == dmas_pkg::RS_SRC) ? src0_ff
			                                                  : src_w.nxt_addr;
		nxt_dst = ws_dst ? mrg(dst_ff) : dst_ff;
		if (unit_done && upd_dst)
			nxt_dst = (rpt_hit && rside == dmas_pkg::RS_DST) ? dst0_ff
			                                                  : dst_w.nxt_addr;
		nxt_tcnt = ws_tcnt ? mrg(tcnt_ff) : tcnt_ff;
		if (unit_done && !free_run)
			nxt_tcnt = tc_end ? dmas_pkg::RST_ZERO : tcnt_ff - {29'h0, step};
		nxt_bus_addr = bus_addr_ff;
		if (nxt_st == dmas_pkg::SM_RD)
			nxt_bus_addr = nxt_src;
		else if (nxt_st == dmas_pkg::SM_WR)
			nxt_bus_addr = nxt_dst;
		else if (nxt_st == dmas_pkg::SM_SGL)
			nxt_bus_addr = dir ? nxt_dst : nxt_src;
		st_set = '0;
		st_set[dmas_pkg::ST_ESF]  = unit_done && ovf_stop && !tc_end;
		st_set[dmas_pkg::ST_END]  = unit_done && tc_end;
		st_set[dmas_pkg::ST_BADA] = bad_area;
		st_clr = ws_stat ? (wd_ff[dmas_pkg::STAT_W-1:0] &
		                    {dmas_pkg::STAT_W{ws_ff[0]}}) : '0;
	end

	////////////////////////////////////////////////////////////////////////
	// channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_ff  <= dmas_pkg::RST_ZERO[15:0];
			area_ff  <= dmas_pkg::RST_ZERO[15:0];
			bsize_ff <= dmas_pkg::RST_ZERO[15:0];
			mrss_ff  <= dmas_pkg::RST_ZERO[7:0];
			src_ff   <= dmas_pkg::RST_ZERO;
			dst_ff   <= dmas_pkg::RST_ZERO;
			tcnt_ff  <= dmas_pkg::RST_ZERO;
			stat_ff  <= '0;
			mask_ff  <= '0;
		end else begin
			mode_ff  <= nxt_mode;
			area_ff  <= ws_area ? m_area[15:0] : area_ff;
			bsize_ff <= ws_bsize ? m_bsize[15:0] : bsize_ff;
			mrss_ff  <= ws_mrss ? m_mrss[7:0] : mrss_ff;
			src_ff   <= nxt_src;
			dst_ff   <= nxt_dst;
			tcnt_ff  <= nxt_tcnt;
			// a new event beats a clear in the same cycle
			stat_ff  <= (stat_ff & ~st_clr) | st_set;
			mask_ff  <= ws_mask ? m_mask[dmas_pkg::STAT_W-1:0] : mask_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer and bus registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff       <= dmas_pkg::SM_IDLE;
			bus_addr_ff <= dmas_pkg::RST_ZERO;
			bus_wr_ff   <= 1'b0;
			ack_n_ff    <= 1'b1;
			data_ff     <= dmas_pkg::RST_ZERO;
			src0_ff     <= dmas_pkg::RST_ZERO;
			dst0_ff     <= dmas_pkg::RST_ZERO;
			ucnt_ff     <= 17'h0_0000;
			ovf_pend_ff <= 1'b0;
			mod_pend_ff <= 1'b0;
		end else begin
			st_ff       <= nxt_st;
			bus_addr_ff <= nxt_bus_addr;
			bus_wr_ff   <= nxt_st == dmas_pkg::SM_WR ||
			               (nxt_st == dmas_pkg::SM_SGL && dir);
			ack_n_ff    <= nxt_st != dmas_pkg::SM_SGL;
			if (st_ff == dmas_pkg::SM_RD && bus_done)
				data_ff <= bus_rdata;
			if (en_rise) begin
				src0_ff <= src_ff;
				dst0_ff <= dst_ff;
			end
			if (en_rise)
				ucnt_ff <= 17'h0_0000;
			else if (unit_done)
				ucnt_ff <= rpt_hit ? 17'h0_0000 : ucnt_inc;
			if (en_rise || (unit_done && ovf_stop))
				ovf_pend_ff <= 1'b0;
			else if (unit_done && ovf_hit)
				ovf_pend_ff <= 1'b1;
			// a module request arriving as one is taken is kept
			mod_pend_ff <= mod_hit || (mod_pend_ff && !start);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// external request: three stages, change taken when the last two agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1_ff  <= 1'b1;
			ext_s2_ff  <= 1'b1;
			ext_s3_ff  <= 1'b1;
			ext_lvl_ff <= 1'b1;
		end else begin
			ext_s1_ff <= ext_req_n;
			ext_s2_ff <= ext_s1_ff;
			ext_s3_ff <= ext_s2_ff;
			if (ext_s2_ff == ext_s3_ff)
				ext_lvl_ff <= ext_s3_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite slave handshakes
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			rvalid_ff  <= 1'b0;
			wa_ff      <= dmas_pkg::RST_ZERO[7:0];
			wd_ff      <= dmas_pkg::RST_ZERO;
			ws_ff      <= 4'h0;
			bresp_ff   <= dmas_pkg::RESP_OK;
		end else begin
			if (aw_take)
				wa_ff <= s_axi_awaddr;
			if (w_take) begin
				wd_ff <= s_axi_wdata;
				ws_ff <= s_axi_wstrb;
			end
			aw_hold_ff <= aw_take || (aw_hold_ff && !wr_fire);
			w_hold_ff  <= w_take || (w_hold_ff && !wr_fire);
			if (wr_fire)
				bresp_ff <= ws_hit ? dmas_pkg::RESP_OK : dmas_pkg::RESP_SLVERR;
			bvalid_ff <= wr_fire || (bvalid_ff && !s_axi_bready);
			rvalid_ff <= ar_take || (rvalid_ff && !s_axi_rready);
		end
	end

	// read mux, registered on the address handshake
	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		rd_mux = dmas_pkg::RST_ZERO;
		if (s_axi_araddr == dmas_pkg::OFS_MODE)
			rd_mux = {16'h0, mode_ff};
		else if (s_axi_araddr == dmas_pkg::OFS_SRC)
			rd_mux = src_ff;
		else if (s_axi_araddr == dmas_pkg::OFS_DST)
			rd_mux = dst_ff;
		else if (s_axi_araddr == dmas_pkg::OFS_TCNT)
			rd_mux = tcnt_ff;
		else if (s_axi_araddr == dmas_pkg::OFS_BSIZE)
			rd_mux = {16'h0, bsize_ff};
		else if (s_axi_araddr == dmas_pkg::OFS_AREA)
			rd_mux = {16'h0, area_ff};
		else if (s_axi_araddr == dmas_pkg::OFS_MRSS)
			rd_mux = {24'h0, mrss_ff};
		else if (s_axi_araddr == dmas_pkg::OFS_STAT)
			rd_mux = {29'h0, stat_ff};
		else if (s_axi_araddr == dmas_pkg::OFS_MASK)
			rd_mux = {29'h0, mask_ff};
		else
			rd_hit = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_ff <= dmas_pkg::RST_ZERO;
			rresp_ff <= dmas_pkg::RESP_OK;
		end else if (ar_take) begin
			rdata_ff <= rd_mux;
			rresp_ff <= rd_hit ? dmas_pkg::RESP_OK : dmas_pkg::RESP_SLVERR;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign bus_req       = st_ff == dmas_pkg::SM_RD || st_ff == dmas_pkg::SM_WR
	                    || st_ff == dmas_pkg::SM_SGL;
	assign bus_addr      = bus_addr_ff;
	assign bus_wr        = bus_wr_ff;
	assign bus_size      = size;
	assign bus_wdata     = data_ff;
	assign periph_ack_strobe_n = ack_n_ff;
	assign irq           = |(stat_ff & mask_ff);

endmodule

// *** dmas_bus_model.sv ***
`timescale 1ns/1ns
module dmas_bus_model (
	// bus cycle from the channel
	input  wire logic        aclk,
	input  wire logic        bus_req,
	input  wire logic        bus_wr,
	input  wire logic [31:0] bus_addr,
	input  wire logic [31:0] bus_wdata,
	// answer
	output logic [31:0]      bus_rdata,
	output logic             bus_done,
	// three wait states per cycle when set
	input  wire logic        slow
);
	logic [31:0] mem [64];
	logic [31:0] last_ff = '0;
	logic [1:0]  wait_ff = '0;

	// done after the waits; data only in a read answer, else it toggles
	assign bus_done  = bus_req && (wait_ff == (slow ? 2'h3 : 2'h0));
	assign bus_rdata = (bus_done && !bus_wr) ? mem[bus_addr[7:2]] : ~last_ff;

	// word i starts as a pattern naming its own index
	initial for (int i = 0; i < 64; i++) mem[i] = 32'h5a00_0000 | 32'(i);

	// wait counter, released-line pattern, memory writes
	always @(posedge aclk) begin
		wait_ff <= (bus_req && !bus_done) ? wait_ff + 2'h1 : 2'h0;
		last_ff <= bus_rdata;
		if (bus_done && bus_wr)
			mem[bus_addr[7:2]] <= bus_wdata;
	end
endmodule

// *** dmas_checker.sv ***
`timescale 1ns/1ns
module dmas_checker (
	// watched top ports
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        bus_req,
	input wire logic [31:0] bus_addr,
	input wire logic        bus_wr,
	input wire logic [31:0] bus_wdata,
	input wire logic [31:0] bus_rdata,
	input wire logic        bus_done,
	input wire logic        periph_ack_strobe_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////
	// system bus
	a_ack_in_cycle: assert property (!periph_ack_strobe_n |-> bus_req)
		else $error("ack strobe low outside a bus cycle");
	a_write_follows_read: assert property (bus_req && !bus_wr &&
		periph_ack_strobe_n && bus_done |=> bus_req && bus_wr &&
		bus_wdata == $past(bus_rdata)) else $error("write not after read");
	a_write_not_first: assert property ($rose(bus_req) |->
		!bus_wr || !periph_ack_strobe_n) else $error("dual write first");
	a_single_no_write: assert property (!periph_ack_strobe_n &&
		bus_done |=> !(bus_req && bus_wr && periph_ack_strobe_n))
		else $error("single transfer took a second cycle");
	a_cycle_holds: assert property (bus_req && !bus_done |=> bus_req &&
		$stable(bus_addr) && $stable(periph_ack_strobe_n))
		else $error("bus cycle changed before done");

	////////////////////////////////////////////////////////////////////////
	// register bus
	a_read_answered: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read not answered");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("bvalid dropped");
	a_arready_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
endmodule

bind dmas_channel dmas_checker chk (.*);

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
	logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        mod_irq_valid = 0, ext_req_n = 1, slow = 0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, mod_irq_vec = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, bus_addr, bus_wdata, bus_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bus_size, rs;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, bus_req, bus_wr, bus_done;
	logic        periph_ack_strobe_n, irq;
	logic [31:0] rd;
	int          error_cnt = 0, check_count = 0, cyc = 0, n_sgl = 0, n_wr = 0;

	dmas_channel dut (.*);
	dmas_bus_model bm (.*);

	// clock; bus cycle counts; hang guard
	initial forever #2 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		n_sgl += int'(bus_done && !periph_ack_strobe_n);
		n_wr += int'(bus_done && bus_wr);
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// write: both channels offered, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rdr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// poll status until a flag in the mask shows, giving up after 300 reads
	task automatic wait_st(input logic [31:0] m);
		rd = '0;
		for (int i = 0; i < 300 && (rd & m) == '0; i++)
			rdr(dmas_pkg::OFS_STAT);
	endtask
	task automatic go(input logic [31:0] md, sa, da, tc, ar);
		wr(dmas_pkg::OFS_SRC, sa);
		wr(dmas_pkg::OFS_DST, da);
		wr(dmas_pkg::OFS_TCNT, tc);
		wr(dmas_pkg::OFS_AREA, ar);
		wr(dmas_pkg::OFS_MODE, md);
	endtask
	task automatic pulse(input logic [7:0] v);
		mod_irq_vec <= v;
		mod_irq_valid <= 1'b1;
		@(posedge aclk);
		mod_irq_valid <= 1'b0;
		repeat (12) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdr(dmas_pkg::OFS_MRSS);
		chk("select reset", 32'h0000_0000, rd);
		wr(dmas_pkg::OFS_MRSS, 32'hffff_ffa5);
		rdr(dmas_pkg::OFS_MRSS);
		chk("select rw", 32'h0000_00a5, rd);
		wr(8'h40, 32'h0000_0001);
		chk("unmapped write", 32'h0000_0002, 32'(rs));
		rdr(8'h40);
		chk("unmapped", 32'h0000_0002, 32'(rs));
	endtask
	// bad code is flagged; irq follows the mask and the clear
	task automatic t_bad_area;
		wr(dmas_pkg::OFS_AREA, 32'h0000_1c00);
		chk("masked irq", 32'h0, 32'(irq));
		wr(dmas_pkg::OFS_MASK, 32'h0000_0004);
		chk("raised irq", 32'h1, 32'(irq));
		wr(dmas_pkg::OFS_STAT, 32'h0000_0007);
		chk("cleared irq", 32'h0, 32'(irq));
	endtask
	// four longwords into an 8-byte window: last two land on top
	task automatic t_wrap(input int n0);
		go(32'h0000_1641, 32'h0, 32'h40, 32'h10, 32'h0000_0003);
		wait_st(32'h2);
		chk("wrap word", 32'h5a00_0002, bm.mem[16]);
		chk("wrap word", 32'h5a00_0003, bm.mem[17]);
		chk("units", 32'd4, 32'(n_wr - n0));
		chk("unit size", 32'h2, 32'(bus_size));
		wr(dmas_pkg::OFS_STAT, 32'h0000_0007);
	endtask
	// slow bus; overflow with enable set stops after two units
	task automatic t_stop(input int n0);
		slow <= 1'b1;
		go(32'h0000_1641, 32'h0, 32'h80, 32'h10, 32'h0000_0083);
		wait_st(32'h1);
		rdr(dmas_pkg::OFS_MODE);
		chk("enable", 32'h0, 32'(rd[0]));
		chk("units", 32'd2, 32'(n_wr - n0));
		wr(dmas_pkg::OFS_STAT, 32'h0000_0007);
		slow <= 1'b0;
	endtask
	task automatic t_single(input int n0, s0);
		go(32'h0000_0643, 32'h0, 32'h0, 32'h8, 32'h0);
		wait_st(32'h2);
		chk("single units", 32'd2, 32'(n_sgl - s0));
		chk("no writes", 32'd0, 32'(n_wr - n0));
		wr(dmas_pkg::OFS_STAT, 32'h0000_0007);
	endtask
	task automatic t_act;
		int n0;
		n0 = n_wr;
		wr(dmas_pkg::OFS_MRSS, 32'h0000_0021);
		go(32'h0000_1611, 32'h0, 32'hc0, 32'h4, 32'h0);
		pulse(8'h22);
		chk("other vector", 32'd0, 32'(n_wr - n0));
		pulse(8'h21);
		chk("own vector", 32'd1, 32'(n_wr - n0));
		wr(dmas_pkg::OFS_STAT, 32'h0000_0007);
		wr(dmas_pkg::OFS_MRSS, 32'h0000_0000);
		go(32'h0000_1611, 32'h0, 32'hc0, 32'h4, 32'h0);
		pulse(8'h00);
		chk("no source", 32'd1, 32'(n_wr - n0));
		go(32'h0000_1621, 32'h0, 32'hc0, 32'h4, 32'h0);
		ext_req_n <= 1'b0;
		wait_st(32'h2);
		ext_req_n <= 1'b1;
		chk("ext request", 32'd2, 32'(n_wr - n0));
		wr(dmas_pkg::OFS_STAT, 32'h0000_0007);
	endtask
	// source repeats every two units: words 0 and 1 land twice
	task automatic t_rpt(input int n0);
		wr(dmas_pkg::OFS_BSIZE, 32'h0000_0002);
		go(32'h0000_5645, 32'h0, 32'h60, 32'h10, 32'h0);
		wait_st(32'h2);
		chk("repeat word", 32'h5a00_0000, bm.mem[26]);
		chk("repeat word", 32'h5a00_0001, bm.mem[27]);
		chk("units", 32'd4, 32'(n_wr - n0));
		wr(dmas_pkg::OFS_STAT, 32'h0000_0007);
	endtask
	// zero count runs until software stops it
	task automatic t_free(input int n0);
		go(32'h0000_1641, 32'h0, 32'hc0, 32'h0, 32'h0000_0003);
		repeat (60) @(posedge aclk);
		wr(dmas_pkg::OFS_MODE, 32'h0);
		chk("free run", 32'h1, 32'(n_wr - n0 > 8));
		rdr(dmas_pkg::OFS_STAT);
		chk("no end", 32'h0, 32'(rd[1]));
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_bad_area();
		t_wrap(n_wr);
		t_stop(n_wr);
		t_single(n_wr, n_sgl);
		t_act();
		t_rpt(n_wr);
		t_free(n_wr);
		conclude();
	end
endmodule
